//--- design/mac_pkg.sv
package mac_pkg;

   // ----------------------------------------------------------------
   // register offsets in device 0 configuration space
   // ----------------------------------------------------------------
   localparam logic [7:0] MAC_OFF_RATE_POLICY  = 8'h50;
   localparam logic [7:0] MAC_OFF_APERTURE_CTL = 8'h51;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int MAC_BIT_LOCAL_RATE  = 4;
   localparam int MAC_BIT_PAGE_POLICY = 3;
   localparam int MAC_BIT_SYS_RATE    = 2;
   localparam int MAC_BIT_PATH_LOCK   = 2;
   localparam int MAC_BIT_AP_ENABLE   = 1;
   localparam int MAC_BIT_PATH_SELECT = 0;

   // ----------------------------------------------------------------
   // reset values and fixed read values
   // ----------------------------------------------------------------
   localparam logic       MAC_RST_PAGE_POLICY = 1'b0;
   localparam logic       MAC_RST_PATH_LOCK   = 1'b0;
   localparam logic       MAC_RST_AP_ENABLE   = 1'b0;
   localparam logic       MAC_RST_PATH_SELECT = 1'b0;
   localparam logic [7:0] MAC_READ_ONES       = 8'hFF;
   localparam logic [7:0] MAC_READ_ZERO       = 8'h00;
   localparam logic [1:0] MAC_SPACE_CTL_OFF   = 2'h0;

   // ----------------------------------------------------------------
   // configuration device numbers
   // ----------------------------------------------------------------
   localparam logic [1:0] MAC_DEV_HOST   = 2'h0;
   localparam logic [1:0] MAC_DEV_BRIDGE = 2'h1;
   localparam logic [1:0] MAC_DEV_GFX    = 2'h2;

   // number of aperture requesters: processor, primary pci, second port
   localparam int MAC_AP_PORTS = 3;

endpackage : mac_pkg

//--- design/mac_page_close.sv
`timescale 1ns/10ps
module mac_page_close (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic ce,
   input  wire logic page_close_policy,
   input  wire logic page_miss,
   input  wire logic row_change_open,
   input  wire logic refresh_start,
   output logic      precharge_bank,
   output logic      precharge_all
);

   typedef struct packed {
      logic pre_bank;
      logic pre_all;
   } mac_pc_state_t;

   mac_pc_state_t s_q;
   mac_pc_state_t s_d;

   // ----------------------------------------------------------------
   // precharge command choice
   // ----------------------------------------------------------------
   // precharge all wins over bank precharge: it already closes the bank
   always_comb begin
      s_d = s_q;
      s_d.pre_all = (page_miss && page_close_policy)
                    || row_change_open || refresh_start;
      s_d.pre_bank = page_miss && !page_close_policy && !s_d.pre_all;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign precharge_bank = s_q.pre_bank;
   assign precharge_all  = s_q.pre_all;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   property p_open_miss;
      ce && page_miss && !page_close_policy && !row_change_open && !refresh_start
         |=> precharge_bank && !precharge_all;
   endproperty
   a_open_miss: assert property (p_open_miss) else $error("open policy miss wrong");

   property p_closed_miss;
      ce && page_miss && page_close_policy |=> precharge_all && !precharge_bank;
   endproperty
   a_closed_miss: assert property (p_closed_miss) else $error("closed policy miss wrong");

   property p_row_refresh;
      ce && (row_change_open || refresh_start) |=> precharge_all;
   endproperty
   a_row_refresh: assert property (p_row_refresh) else $error("no precharge all");

   c_bank: cover property (ce && page_miss && !page_close_policy ##1 precharge_bank);
   c_refresh: cover property (ce && refresh_start ##1 precharge_all);

endmodule : mac_page_close

//--- design/mac_regs.sv
`timescale 1ns/10ps
module mac_regs #(
   parameter bit FULL_LOCAL_MEM = 1'b1  // 0 for variants without local graphics memory
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   // reset straps
   input  wire logic        local_mem_rate_strap,
   input  wire logic        system_mem_rate_strap_pin,
   // configuration cycles, byte wide
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [1:0]  cfg_dev,
   input  wire logic [7:0]  cfg_off,
   input  wire logic [7:0]  cfg_wdata,
   input  wire logic        cfg_agp_reg,
   input  wire logic [7:0]  cfg_ext_rdata,
   output logic [7:0]       cfg_rdata,
   output logic             cfg_rack,
   // system management space control field
   input  wire logic [1:0]  system_mgmt_space_control,
   // aperture requests from processor, primary pci, second port
   input  wire logic [2:0]  ap_req,
   output logic [2:0]       ap_gnt,
   // clock selects and visibility
   output logic             local_mem_clk_133,
   output logic             sys_mem_clk_133,
   output logic             bridge_dev_en,
   output logic             gfx_dev_en,
   output logic             gfx_path_mode,
   // dram controller side
   input  wire logic        page_miss,
   input  wire logic        row_change_open,
   input  wire logic        refresh_start,
   output logic             precharge_bank,
   output logic             precharge_all
);

   typedef struct packed {
      logic       local_rate;
      logic       page_policy;
      logic       sys_rate;
      logic       path_lock;
      logic       lock_used;
      logic       ap_enable;
      logic       path_select;
      logic [7:0] rdata;
      logic       rack;
      logic [2:0] gnt;
      logic       bridge_en;
      logic       gfx_en;
   } mac_state_t;

   mac_state_t s_q;
   mac_state_t s_d;

   logic       wr_rate;
   logic       wr_ap;
   logic [7:0] rate_view;
   logic [7:0] ap_view;
   logic       gfx_claim;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // only device 0 holds these two registers
   assign wr_rate = cfg_wr && (cfg_dev == mac_pkg::MAC_DEV_HOST)
                    && (cfg_off == mac_pkg::MAC_OFF_RATE_POLICY);
   assign wr_ap   = cfg_wr && (cfg_dev == mac_pkg::MAC_DEV_HOST)
                    && (cfg_off == mac_pkg::MAC_OFF_APERTURE_CTL);

   // graphics device claims cycles only in graphics mode with space control set
   assign gfx_claim = s_q.path_select
                      && (system_mgmt_space_control != mac_pkg::MAC_SPACE_CTL_OFF);

   // ----------------------------------------------------------------
   // read views, reserved bits zero
   // ----------------------------------------------------------------
   always_comb begin
      rate_view = 8'h00;
      rate_view[mac_pkg::MAC_BIT_LOCAL_RATE]  = s_q.local_rate;
      rate_view[mac_pkg::MAC_BIT_PAGE_POLICY] = s_q.page_policy;
      rate_view[mac_pkg::MAC_BIT_SYS_RATE]    = s_q.sys_rate;
      ap_view = 8'h00;
      ap_view[mac_pkg::MAC_BIT_PATH_LOCK]   = s_q.path_lock;
      ap_view[mac_pkg::MAC_BIT_AP_ENABLE]   = s_q.ap_enable;
      ap_view[mac_pkg::MAC_BIT_PATH_SELECT] = s_q.path_select;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rack = 1'b0;
      // rate and policy register, reserved bits dropped
      if (wr_rate) begin
         // reduced variants keep the bit at zero so 133 MHz is unreachable
         s_d.local_rate  = FULL_LOCAL_MEM
                           && cfg_wdata[mac_pkg::MAC_BIT_LOCAL_RATE];
         s_d.page_policy = cfg_wdata[mac_pkg::MAC_BIT_PAGE_POLICY];
         s_d.sys_rate    = cfg_wdata[mac_pkg::MAC_BIT_SYS_RATE];
      end
      // aperture control register
      if (wr_ap) begin
         if (!s_q.lock_used) begin
            s_d.path_lock = cfg_wdata[mac_pkg::MAC_BIT_PATH_LOCK];
            s_d.lock_used = 1'b1;
         end
         s_d.ap_enable = cfg_wdata[mac_pkg::MAC_BIT_AP_ENABLE];
         // the lock in force before this write decides
         if (!s_q.path_lock) begin
            s_d.path_select = cfg_wdata[mac_pkg::MAC_BIT_PATH_SELECT];
         end
      end
      // read answer; a write in the same cycle takes precedence
      if (cfg_rd && !cfg_wr) begin
         s_d.rack = 1'b1;
         case (cfg_dev)
            mac_pkg::MAC_DEV_HOST: begin
               if (cfg_off == mac_pkg::MAC_OFF_RATE_POLICY) begin
                  s_d.rdata = rate_view;
               end else if (cfg_off == mac_pkg::MAC_OFF_APERTURE_CTL) begin
                  s_d.rdata = ap_view;
               end else if (s_q.path_select && cfg_agp_reg) begin
                  s_d.rdata = mac_pkg::MAC_READ_ZERO;
               end else begin
                  s_d.rdata = cfg_ext_rdata;
               end
            end
            mac_pkg::MAC_DEV_BRIDGE: begin
               // hidden device behaves as if absent
               s_d.rdata = !s_q.path_select ? cfg_ext_rdata
                                            : mac_pkg::MAC_READ_ONES;
            end
            mac_pkg::MAC_DEV_GFX: begin
               s_d.rdata = gfx_claim ? cfg_ext_rdata
                                     : mac_pkg::MAC_READ_ONES;
            end
            default: begin
               s_d.rdata = cfg_ext_rdata;
            end
         endcase
      end
      // visibility outputs lag the select by one cycle; read routing above
      // uses the select itself, so a read right after a select write is right
      s_d.bridge_en = !s_q.path_select;
      s_d.gfx_en    = gfx_claim;
      // aperture gate, one flop so the grant is clean
      s_d.gnt = ap_req & {mac_pkg::MAC_AP_PORTS{s_q.ap_enable}};
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // straps are sampled on every reset edge, so the last one before release wins
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_q             <= '0;
         s_q.local_rate  <= FULL_LOCAL_MEM && local_mem_rate_strap;
         s_q.sys_rate    <= system_mem_rate_strap_pin;
         s_q.page_policy <= mac_pkg::MAC_RST_PAGE_POLICY;
         s_q.path_lock   <= mac_pkg::MAC_RST_PATH_LOCK;
         s_q.ap_enable   <= mac_pkg::MAC_RST_AP_ENABLE;
         s_q.path_select <= mac_pkg::MAC_RST_PATH_SELECT;
         s_q.bridge_en   <= 1'b1;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // a set bit means 133 MHz, a clear bit 100 MHz
   assign local_mem_clk_133 = s_q.local_rate;
   assign sys_mem_clk_133   = s_q.sys_rate;
   assign cfg_rdata         = s_q.rdata;
   assign cfg_rack          = s_q.rack;
   assign ap_gnt            = s_q.gnt;
   assign bridge_dev_en     = s_q.bridge_en;
   assign gfx_dev_en        = s_q.gfx_en;
   assign gfx_path_mode     = s_q.path_select;

   // ----------------------------------------------------------------
   // page closing engine
   // ----------------------------------------------------------------
   mac_page_close u_page_close (
      .clk               (clk),
      .nrst              (nrst),
      .ce                (ce),
      .page_close_policy (s_q.page_policy),
      .page_miss         (page_miss),
      .row_change_open   (row_change_open),
      .refresh_start     (refresh_start),
      .precharge_bank    (precharge_bank),
      .precharge_all     (precharge_all)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   property p_local_strap;
      $past(nrst) == 1'b0 |-> local_mem_clk_133 == (FULL_LOCAL_MEM && $past(local_mem_rate_strap));
   endproperty
   a_local_strap: assert property (p_local_strap) else $error("local rate not from strap");

   property p_local_forced;
      wr_rate && ce |=> local_mem_clk_133 == (FULL_LOCAL_MEM && $past(cfg_wdata[4]));
   endproperty
   a_local_forced: assert property (p_local_forced) else $error("local rate write wrong");

   property p_sys_strap;
      $past(nrst) == 1'b0 |-> sys_mem_clk_133 == $past(system_mem_rate_strap_pin);
   endproperty
   a_sys_strap: assert property (p_sys_strap) else $error("system rate not from strap");

   property p_lock_once;
      s_q.lock_used |=> $stable(s_q.path_lock);
   endproperty
   a_lock_once: assert property (p_lock_once) else $error("lock changed twice");

   property p_select_frozen;
      s_q.path_lock |=> $stable(gfx_path_mode);
   endproperty
   a_select_frozen: assert property (p_select_frozen) else $error("locked select changed");

   property p_ap_block;
      ce && !s_q.ap_enable |=> ap_gnt == 3'h0;
   endproperty
   a_ap_block: assert property (p_ap_block) else $error("aperture passed while off");

   property p_gfx_hidden;
      ce && cfg_rd && !cfg_wr && cfg_dev == 2'h2 && !gfx_path_mode
         |=> cfg_rack && cfg_rdata == 8'hFF;
   endproperty
   a_gfx_hidden: assert property (p_gfx_hidden) else $error("hidden device 2 read wrong");

   property p_bridge_hidden;
      ce && cfg_rd && !cfg_wr && cfg_dev == 2'h1 && gfx_path_mode
         |=> cfg_rdata == 8'hFF;
   endproperty
   a_bridge_hidden: assert property (p_bridge_hidden) else $error("hidden device 1 read wrong");

   property p_gfx_claim;
      ce |=> gfx_dev_en == ($past(gfx_path_mode) && $past(system_mgmt_space_control) != 2'h0);
   endproperty
   a_gfx_claim: assert property (p_gfx_claim) else $error("graphics claim wrong");

   property p_reserved_zero;
      ce && cfg_rd && !cfg_wr && cfg_dev == 2'h0 && cfg_off == 8'h51
         |=> cfg_rdata[7:3] == 5'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

   // ----------------------------------------------------------------
   // checks on stored fields and read routing
   // ----------------------------------------------------------------
   property p_rate_read;
      ce && cfg_rd && !cfg_wr && cfg_dev == mac_pkg::MAC_DEV_HOST
         && cfg_off == mac_pkg::MAC_OFF_RATE_POLICY
         |=> cfg_rdata == {3'h0, local_mem_clk_133, s_q.page_policy, sys_mem_clk_133, 2'h0};
   endproperty
   a_rate_read: assert property (p_rate_read) else $error("rate register read wrong");

   property p_reduced_zero;
      !FULL_LOCAL_MEM |-> !local_mem_clk_133;
   endproperty
   a_reduced_zero: assert property (p_reduced_zero) else $error("reduced local rate set");

   property p_full_store;
      FULL_LOCAL_MEM && ce && wr_rate
         |=> local_mem_clk_133 == $past(cfg_wdata[mac_pkg::MAC_BIT_LOCAL_RATE]);
   endproperty
   a_full_store: assert property (p_full_store) else $error("local rate not stored");

   property p_policy_store;
      ce && wr_rate |=> s_q.page_policy == $past(cfg_wdata[mac_pkg::MAC_BIT_PAGE_POLICY]);
   endproperty
   a_policy_store: assert property (p_policy_store) else $error("policy not stored");

   // the rate bits move only on a write to their own register
   property p_local_hold;
      !(ce && wr_rate) |=> $stable(local_mem_clk_133);
   endproperty
   a_local_hold: assert property (p_local_hold) else $error("local rate moved");

   property p_sys_hold;
      !(ce && wr_rate) |=> $stable(sys_mem_clk_133);
   endproperty
   a_sys_hold: assert property (p_sys_hold) else $error("system rate moved");

   property p_lock_first;
      ce && wr_ap && !s_q.lock_used
         |=> s_q.path_lock == $past(cfg_wdata[mac_pkg::MAC_BIT_PATH_LOCK]);
   endproperty
   a_lock_first: assert property (p_lock_first) else $error("first lock write lost");

   property p_select_open;
      ce && wr_ap && !s_q.path_lock
         |=> gfx_path_mode == $past(cfg_wdata[mac_pkg::MAC_BIT_PATH_SELECT]);
   endproperty
   a_select_open: assert property (p_select_open) else $error("open select not written");

   property p_ap_store;
      ce && wr_ap |=> s_q.ap_enable == $past(cfg_wdata[mac_pkg::MAC_BIT_AP_ENABLE]);
   endproperty
   a_ap_store: assert property (p_ap_store) else $error("aperture enable lost");

   property p_ap_pass;
      ce && s_q.ap_enable |=> ap_gnt == $past(ap_req);
   endproperty
   a_ap_pass: assert property (p_ap_pass) else $error("aperture grant lost");

   property p_bridge_shown;
      ce && cfg_rd && !cfg_wr && cfg_dev == mac_pkg::MAC_DEV_BRIDGE && !gfx_path_mode
         |=> cfg_rdata == $past(cfg_ext_rdata);
   endproperty
   a_bridge_shown: assert property (p_bridge_shown) else $error("device 1 read wrong");

   property p_agp_zero;
      ce && cfg_rd && !cfg_wr && cfg_dev == mac_pkg::MAC_DEV_HOST && cfg_agp_reg
         && gfx_path_mode && cfg_off != mac_pkg::MAC_OFF_RATE_POLICY
         && cfg_off != mac_pkg::MAC_OFF_APERTURE_CTL |=> cfg_rdata == 8'h00;
   endproperty
   a_agp_zero: assert property (p_agp_zero) else $error("agp register not zero");

   property p_gfx_ignored;
      ce && cfg_rd && !cfg_wr && cfg_dev == mac_pkg::MAC_DEV_GFX
         && system_mgmt_space_control == mac_pkg::MAC_SPACE_CTL_OFF |=> cfg_rdata == 8'hFF;
   endproperty
   a_gfx_ignored: assert property (p_gfx_ignored) else $error("device 2 answered");

   property p_bridge_out;
      ce |=> bridge_dev_en == !$past(gfx_path_mode);
   endproperty
   a_bridge_out: assert property (p_bridge_out) else $error("bridge visibility wrong");

   c_lock_write: cover property (wr_ap && ce ##1 s_q.path_lock);
   c_gfx_mode: cover property (gfx_dev_en && cfg_rack);
   c_ap_grant: cover property (ap_gnt != 3'h0);

endmodule : mac_regs

//--- dv/mac_host_model.sv
`timescale 1ns/10ps
module mac_host_model #(
   parameter bit GMS_ZERO = 1'b1  // graphics memory select field reads 00
) (
   input  wire logic       clk,
   output logic            cfg_wr,
   output logic            cfg_rd,
   output logic [1:0]      cfg_dev,
   output logic [7:0]      cfg_off,
   output logic [7:0]      cfg_wdata,
   output logic            cfg_agp_reg,
   input  wire logic [7:0] cfg_rdata,
   input  wire logic       cfg_rack
);
   // ---------------------------------------------------------------
   // idle bus
   // ---------------------------------------------------------------
   initial begin
      cfg_wr      = 1'b0;
      cfg_rd      = 1'b0;
      cfg_dev     = 2'h0;
      cfg_off     = 8'h00;
      cfg_wdata   = 8'h00;
      cfg_agp_reg = 1'b0;
   end

   // one byte, request held over exactly one rising edge
   task automatic wr(input logic [1:0] dev, input logic [7:0] off, input logic [7:0] data);
      @(negedge clk);
      cfg_dev   = dev;
      cfg_off   = off;
      cfg_wdata = data;
      cfg_wr    = 1'b1;
      @(negedge clk);
      cfg_wr    = 1'b0;
      cfg_wdata = ~data;  // no stale byte left on the bus
   endtask : wr

   // read pulse, then a bounded wait for the answer
   task automatic rd(input logic [1:0] dev, input logic [7:0] off, input logic agp,
                     output logic [7:0] data, output logic ok);
      int n;
      @(negedge clk);
      cfg_dev     = dev;
      cfg_off     = off;
      cfg_agp_reg = agp;
      cfg_rd      = 1'b1;
      @(negedge clk);
      cfg_rd = 1'b0;
      n = 0;
      while (cfg_rack !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      ok   = (cfg_rack === 1'b1);
      data = cfg_rdata;
   endtask : rd

   // local rate only touched with the graphics device off
   task automatic wr_rate(input logic [7:0] data);
      if (GMS_ZERO) begin
         wr(2'h0, mac_pkg::MAC_OFF_RATE_POLICY, data);
      end
   endtask : wr_rate

   // path select is the first access after reset
   task automatic set_path(input logic [7:0] data);
      wr(2'h0, mac_pkg::MAC_OFF_APERTURE_CTL, data);
   endtask : set_path

   // range and translation table are in place before this call
   task automatic open_aperture(input logic [7:0] data);
      wr(2'h0, mac_pkg::MAC_OFF_APERTURE_CTL, data);
   endtask : open_aperture
endmodule : mac_host_model

//--- dv/mac_regs_bench.sv
`timescale 1ns/10ps
module mac_regs_bench;
   logic       clk = 1'b0, nrst = 1'b0, strap_l = 1'b1, strap_s = 1'b1, ce = 1'b1;
   logic       cfg_wr, cfg_rd, cfg_agp_reg, cfg_rack, r_local, r_rack;
   logic [1:0] cfg_dev, space_ctl = 2'h0;
   logic [7:0] cfg_off, cfg_wdata, cfg_rdata, r_rdata;
   logic [2:0] ap_req = 3'h0, ap_gnt;
   logic       miss = 1'b0, row = 1'b0, refr = 1'b0, pc_bank, pc_all;
   logic       l133, s133, br_en, gfx_en, path;
   int         n_mismatch = 0, comparisons = 0, cycles = 0;
   localparam logic [7:0] EXT = 8'h5A;
   logic [7:0] ext = EXT;
   localparam logic [7:0] APC = mac_pkg::MAC_OFF_APERTURE_CTL;
   localparam logic [7:0] RPP = mac_pkg::MAC_OFF_RATE_POLICY;

   always #20 clk = ~clk;

   mac_host_model host_u (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_dev(cfg_dev),
      .cfg_off(cfg_off), .cfg_wdata(cfg_wdata), .cfg_agp_reg(cfg_agp_reg),
      .cfg_rdata(cfg_rdata), .cfg_rack(cfg_rack));

   mac_regs dut_u (.clk(clk), .nrst(nrst), .ce(ce), .local_mem_rate_strap(strap_l),
      .system_mem_rate_strap_pin(strap_s), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_dev(cfg_dev), .cfg_off(cfg_off), .cfg_wdata(cfg_wdata), .cfg_agp_reg(cfg_agp_reg),
      .cfg_ext_rdata(ext), .cfg_rdata(cfg_rdata), .cfg_rack(cfg_rack),
      .system_mgmt_space_control(space_ctl), .ap_req(ap_req), .ap_gnt(ap_gnt),
      .local_mem_clk_133(l133), .sys_mem_clk_133(s133), .bridge_dev_en(br_en),
      .gfx_dev_en(gfx_en), .gfx_path_mode(path), .page_miss(miss), .row_change_open(row),
      .refresh_start(refr), .precharge_bank(pc_bank), .precharge_all(pc_all));

   // reduced variant sharing all inputs
   mac_regs #(.FULL_LOCAL_MEM(1'b0)) dut_r_u (.clk(clk), .nrst(nrst), .ce(ce),
      .local_mem_rate_strap(strap_l), .system_mem_rate_strap_pin(strap_s), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_dev(cfg_dev), .cfg_off(cfg_off), .cfg_wdata(cfg_wdata),
      .cfg_agp_reg(cfg_agp_reg), .cfg_ext_rdata(ext), .cfg_rdata(r_rdata), .cfg_rack(r_rack),
      .system_mgmt_space_control(space_ctl), .ap_req(ap_req), .ap_gnt(),
      .local_mem_clk_133(r_local), .sys_mem_clk_133(), .bridge_dev_en(), .gfx_dev_en(),
      .gfx_path_mode(), .page_miss(miss), .row_change_open(row), .refresh_start(refr),
      .precharge_bank(), .precharge_all());

   // ---------------------------------------------------------------
   // shared checks
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // masked read compare; the mask hides bits not under test
   task automatic rchk(input logic [1:0] dev, input logic [7:0] off, input logic agp,
                       input logic [7:0] mask, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      host_u.rd(dev, off, agp, d, ok);
      check(8'(ok), 8'h01);
      check(d & mask, exp);
   endtask : rchk

   task automatic do_reset(input logic sl, input logic ss);
      @(negedge clk);
      nrst    = 1'b0;
      strap_l = sl;
      strap_s = ss;
      repeat (4) @(negedge clk);
      nrst = 1'b1;
   endtask : do_reset

   task automatic t_reset_vals(input logic sl, input logic ss, input logic [7:0] pth);
      do_reset(sl, ss);
      check(8'(l133), 8'(sl));
      check(8'(s133), 8'(ss));
      check(8'(r_local), 8'h00);
      check({5'h00, br_en, gfx_en, path}, 8'h04);
      host_u.set_path(pth);
      rchk(2'h0, RPP, 1'b0, 8'hFF, {3'h0, sl, 1'b0, ss, 2'h0});
      check(r_rdata & 8'h10, 8'h00);
      check(8'(r_rack), 8'h01);
   endtask : t_reset_vals

   task automatic t_rate;
      host_u.wr_rate(8'hFF);
      check(8'(l133), 8'h01);
      check(8'(r_local), 8'h00);
      rchk(2'h0, RPP, 1'b0, 8'hFB, 8'h18);
      check(r_rdata & 8'h10, 8'h00);
      host_u.wr_rate(8'h00);
      check(8'(l133), 8'h00);
      rchk(2'h0, RPP, 1'b0, 8'hFB, 8'h00);
   endtask : t_rate

   // clock enable low: a write and a read leave no trace
   task automatic t_freeze;
      logic [7:0] d;
      logic       ok;
      @(negedge clk);
      ce = 1'b0;
      host_u.wr(2'h0, RPP, 8'h1C);
      check({6'h00, l133, s133}, 8'h00);
      host_u.rd(2'h0, RPP, 1'b0, d, ok);
      check(8'(ok), 8'h00);
      @(negedge clk);
      ce = 1'b1;
      rchk(2'h0, RPP, 1'b0, 8'hFF, 8'h00);
   endtask : t_freeze

   task automatic ev(input logic [2:0] in, input logic [1:0] exp);
      @(negedge clk);
      {miss, row, refr} = in;
      @(negedge clk);
      {miss, row, refr} = 3'h0;
      check({6'h00, pc_bank, pc_all}, {6'h00, exp});
   endtask : ev

   task automatic t_page;
      for (int p = 0; p < 2; p++) begin
         host_u.wr_rate({4'h0, p[0], 3'h0});
         ev(3'h4, (p == 0) ? 2'h2 : 2'h1);
         ev(3'h2, 2'h1);
         ev(3'h1, 2'h1);
      end
   endtask : t_page

   task automatic ap(input logic [2:0] req, input logic [2:0] exp);
      @(negedge clk);
      ap_req = req;
      @(negedge clk);
      ap_req = 3'h0;
      check(8'(ap_gnt), 8'(exp));
   endtask : ap

   task automatic t_aperture;
      host_u.set_path(8'h00);
      for (int i = 0; i < 3; i++) ap(3'(1 << i), 3'h0);
      host_u.open_aperture(8'h02);
      for (int i = 0; i < 3; i++) ap(3'(1 << i), 3'(1 << i));
      host_u.wr(2'h0, APC, 8'h00);
      ap(3'h7, 3'h0);
   endtask : t_aperture

   task automatic t_visible;
      rchk(2'h2, 8'h00, 1'b0, 8'hFF, 8'hFF);
      rchk(2'h1, 8'h00, 1'b0, 8'hFF, EXT);
      rchk(2'h0, 8'h10, 1'b1, 8'hFF, EXT);
      host_u.wr(2'h0, APC, 8'h05);
      rchk(2'h0, APC, 1'b0, 8'hFF, 8'h01);
      check({7'h00, br_en}, 8'h00);
      rchk(2'h1, 8'h00, 1'b0, 8'hFF, 8'hFF);
      rchk(2'h0, 8'h10, 1'b1, 8'hFF, 8'h00);
      rchk(2'h0, 8'h10, 1'b0, 8'hFF, EXT);
      rchk(2'h2, 8'h00, 1'b0, 8'hFF, 8'hFF);
      check(8'(gfx_en), 8'h00);
      space_ctl = 2'h1;
      ext       = 8'hC3;
      rchk(2'h2, 8'h00, 1'b0, 8'hFF, 8'hC3);
      ext       = EXT;
      check(8'(gfx_en), 8'h01);
      host_u.wr(2'h0, APC, 8'hFE);
      rchk(2'h0, APC, 1'b0, 8'hFF, 8'h02);
      space_ctl = 2'h0;
   endtask : t_visible

   task automatic t_lock;
      check(8'(path), 8'h01);
      host_u.wr(2'h0, APC, 8'h00);
      rchk(2'h0, APC, 1'b0, 8'hFF, 8'h05);
      check(8'(path), 8'h01);
   endtask : t_lock

   task automatic tally_and_finish;
      if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   // ---------------------------------------------------------------
   // hang guard, far above the roughly 100 cycles needed
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   initial begin
      t_reset_vals(1'b1, 1'b1, 8'h00);
      t_rate();
      t_freeze();
      t_page();
      t_aperture();
      t_visible();
      t_reset_vals(1'b0, 1'b0, 8'h05);
      t_lock();
      tally_and_finish();
   end
endmodule : mac_regs_bench
